// File: logic/asp_serial_port.sv
// The strobed register port was decided locally.
`timescale 1ns/1ns
`include "asp_params.svh"

module asp_serial_port (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic rxd_i,
   output logic txd_o,
   input wire logic timer1_ovf_i,
   input wire logic double_speed_core_i
);

   // ****************************************************************
   // Software-visible state
   // ****************************************************************
   logic mode_hi_reg, mode_lo_reg, sm2_reg, ren_reg;
   logic tx_ninth_reg, rx_ninth_reg, tx_done_reg, rx_done_reg;
   logic frame_err_reg;
   logic double_reg, fchk_reg;
   logic run_reg, tx_src_reg, rx_src_reg, fast_reg;
   logic [7:0] reload_reg;
   logic [7:0] rx_buf_reg;
   logic [7:0] rdata_reg;
   logic per_phase_reg;

   asp_pkg::asp_mode_t mode;
   assign mode = asp_pkg::asp_mode_t'({mode_hi_reg, mode_lo_reg});

   wire wr_power_control_reg = wr_i && (addr_i == `ASP_ADDR_POWER_CTRL);
   wire wr_reload = wr_i && (addr_i == `ASP_ADDR_BAUD_RELOAD);
   wire wr_serial_control_reg = wr_i && (addr_i == `ASP_ADDR_SERIAL_CTRL);
   wire wr_serial_data_buffer = wr_i && (addr_i == `ASP_ADDR_DATA_BUF);
   wire wr_bdr = wr_i && (addr_i == `ASP_ADDR_BAUD_CTRL);
   wire mode_async = (mode != asp_pkg::ASP_MODE_SHIFT);
   wire mode_8bit = (mode == asp_pkg::ASP_MODE_UART8);
   wire mode_fix9 = (mode == asp_pkg::ASP_MODE_FIX9);

   // ****************************************************************
   // Baud generation
   // ****************************************************************
   wire per_tick = double_speed_core_i | per_phase_reg;
   wire brg_ovf;
   wire tx_tick;
   wire rx_tick;

   // Fixed mode bypasses both sources; timer overflow arrives already
   // divided by six from the timer's own prescale.
   wire tx_src = mode_fix9 ? per_tick :
                 (tx_src_reg ? brg_ovf : timer1_ovf_i);
   wire rx_src = mode_fix9 ? per_tick :
                 (rx_src_reg ? brg_ovf : timer1_ovf_i);

   asp_brg #(.WIDTH(8)) u_brg (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .per_tick_i(per_tick),
      .run_i(run_reg),
      .fast_i(fast_reg),
      .reload_i(reload_reg),
      .overflow_o(brg_ovf)
   );

   asp_half_tick u_tx_tick (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .pulse_i(tx_src),
      .double_i(double_reg),
      .tick_o(tx_tick)
   );

   asp_half_tick u_rx_tick (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .pulse_i(rx_src),
      .double_i(double_reg),
      .tick_o(rx_tick)
   );

   // ****************************************************************
   // Transmitter
   // ****************************************************************
   asp_pkg::asp_tx_state_t tx_state_reg;
   logic [10:0] tx_shift_reg;
   logic [3:0] tx_idx_reg;
   logic [3:0] tx_smp_reg;
   logic txd_reg;

   wire [3:0] tx_last = mode_8bit ? `ASP_STOP_IDX_8BIT : `ASP_STOP_IDX_9BIT;
   wire tx_ninth = mode_8bit ? 1'b1 : tx_ninth_reg;
   wire tx_idle = (tx_state_reg == asp_pkg::ASP_TX_IDLE);
   wire tx_start = wr_serial_data_buffer && mode_async && tx_idle;
   wire tx_bit_end = !tx_idle && tx_tick && (tx_smp_reg == `ASP_SAMPLE_LAST);
   wire tx_set_ti = tx_bit_end && ((tx_idx_reg + 4'h1) == tx_last);

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_state_reg <= asp_pkg::ASP_TX_IDLE;
         tx_shift_reg <= 11'h7FF;
         tx_idx_reg <= 4'h0;
         tx_smp_reg <= 4'h0;
         txd_reg <= 1'b1;
      end else begin
         case (tx_state_reg)
            asp_pkg::ASP_TX_IDLE: begin
               if (tx_start) begin
                  tx_state_reg <= asp_pkg::ASP_TX_SEND;
                  tx_shift_reg <= {1'b1, tx_ninth, wdata_i, 1'b0};
                  tx_idx_reg <= 4'h0;
                  tx_smp_reg <= 4'h0;
                  txd_reg <= 1'b0;
               end
            end
            asp_pkg::ASP_TX_SEND: begin
               if (tx_tick) begin
                  tx_smp_reg <= tx_smp_reg + 4'h1;
               end
               if (tx_bit_end && (tx_idx_reg == tx_last)) begin
                  tx_state_reg <= asp_pkg::ASP_TX_IDLE;
               end else if (tx_bit_end) begin
                  tx_idx_reg <= tx_idx_reg + 4'h1;
                  tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                  txd_reg <= tx_shift_reg[1];
               end
            end
            default: tx_state_reg <= asp_pkg::ASP_TX_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Receiver
   // ****************************************************************
   asp_pkg::asp_rx_state_t rx_state_reg;
   logic [7:0] rx_shift_reg;
   logic [3:0] rx_idx_reg;
   logic [3:0] rx_smp_reg;
   logic [1:0] rx_votes_reg;
   logic rx_prev_reg;

   wire [3:0] rx_last = mode_8bit ? `ASP_STOP_IDX_8BIT : `ASP_STOP_IDX_9BIT;
   wire rx_on = ren_reg && mode_async;
   wire rx_fall = rx_prev_reg && !rxd_i;
   wire rx_active = (rx_state_reg == asp_pkg::ASP_RX_ACTIVE);
   wire rx_maj = (rx_votes_reg[0] & rx_votes_reg[1]) |
                 (rx_votes_reg[0] & rxd_i) |
                 (rx_votes_reg[1] & rxd_i);
   wire rx_decide = rx_active && rx_on && rx_tick &&
                    (rx_smp_reg == `ASP_VOTE_C);
   wire rx_is_data = (rx_idx_reg != 4'h0) &&
                     (rx_idx_reg <= `ASP_LAST_DATA_IDX);
   wire [7:0] rx_data_next = {rx_maj, rx_shift_reg[7:1]};
   wire [3:0] rx_deliver_idx = fchk_reg ? rx_last : rx_last - 4'h1;
   wire rx_deliver = rx_decide && (rx_idx_reg == rx_deliver_idx);
   wire rx_stop_bad = rx_decide && (rx_idx_reg == rx_last) && !rx_maj;
   wire set_ferr = rx_stop_bad && fchk_reg;
   wire set_rx_ninth = rx_decide &&
                       (rx_idx_reg == `ASP_NINTH_IDX);
   wire rx_frame_end = rx_decide &&
                       ((rx_idx_reg == rx_last) ||
                        ((rx_idx_reg == 4'h0) && rx_maj));

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_state_reg <= asp_pkg::ASP_RX_IDLE;
         rx_shift_reg <= 8'h00;
         rx_idx_reg <= 4'h0;
         rx_smp_reg <= 4'h0;
         rx_votes_reg <= 2'h3;
         rx_prev_reg <= 1'b1;
      end else begin
         rx_prev_reg <= rxd_i;
         case (rx_state_reg)
            asp_pkg::ASP_RX_IDLE: begin
               if (rx_on && rx_fall) begin
                  rx_state_reg <= asp_pkg::ASP_RX_ACTIVE;
                  rx_idx_reg <= 4'h0;
                  rx_smp_reg <= 4'h0;
               end
            end
            asp_pkg::ASP_RX_ACTIVE: begin
               if (!rx_on || rx_frame_end) begin
                  rx_state_reg <= asp_pkg::ASP_RX_IDLE;
               end else if (rx_tick) begin
                  rx_smp_reg <= rx_smp_reg + 4'h1;
                  if (rx_smp_reg == `ASP_VOTE_A) begin
                     rx_votes_reg[0] <= rxd_i;
                  end
                  if (rx_smp_reg == `ASP_VOTE_B) begin
                     rx_votes_reg[1] <= rxd_i;
                  end
                  if (rx_smp_reg == `ASP_SAMPLE_LAST) begin
                     rx_idx_reg <= rx_idx_reg + 4'h1;
                  end
               end
               if (rx_decide && rx_is_data) begin
                  rx_shift_reg <= rx_data_next;
               end
            end
            default: rx_state_reg <= asp_pkg::ASP_RX_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Registers and read port
   // ****************************************************************
   // Hardware sets win over a software write in the same cycle so that
   // an event is never lost to a clear racing with it.
   wire tx_done_next = tx_set_ti ? 1'b1 :
      (wr_serial_control_reg ? wdata_i[`ASP_SERIAL_CONTROL_REG_TX_DONE] : tx_done_reg);
   wire rx_done_next = rx_deliver ? 1'b1 :
      (wr_serial_control_reg ? wdata_i[`ASP_SERIAL_CONTROL_REG_RX_DONE] : rx_done_reg);
   wire frame_err_next = set_ferr ? 1'b1 :
      ((wr_serial_control_reg && fchk_reg) ? wdata_i[`ASP_SERIAL_CONTROL_REG_MODE_HI] :
       frame_err_reg);
   wire rx_ninth_next = set_rx_ninth ? rx_maj :
      (wr_serial_control_reg ? wdata_i[`ASP_SERIAL_CONTROL_REG_RX_NINTH] : rx_ninth_reg);
   wire [7:0] rx_buf_next = (rx_idx_reg == `ASP_LAST_DATA_IDX) ?
                            rx_data_next : rx_shift_reg;

   wire [7:0] serial_control_reg_rd = {fchk_reg ? frame_err_reg : mode_hi_reg,
                         mode_lo_reg, sm2_reg, ren_reg, tx_ninth_reg,
                         rx_ninth_reg, tx_done_reg, rx_done_reg};
   wire [7:0] power_control_reg_rd = {double_reg, fchk_reg, 6'h00};
   wire [7:0] bdr_rd = {3'h0, run_reg, tx_src_reg, rx_src_reg, fast_reg,
                        1'b0};
   wire [7:0] rd_value =
      (addr_i == `ASP_ADDR_SERIAL_CTRL) ? serial_control_reg_rd :
      (addr_i == `ASP_ADDR_DATA_BUF) ? rx_buf_reg :
      (addr_i == `ASP_ADDR_POWER_CTRL) ? power_control_reg_rd :
      (addr_i == `ASP_ADDR_BAUD_CTRL) ? bdr_rd :
      (addr_i == `ASP_ADDR_BAUD_RELOAD) ? reload_reg : 8'h00;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {mode_hi_reg, mode_lo_reg, sm2_reg, ren_reg} <= 4'h0;
         tx_ninth_reg <= 1'b0;
         {rx_ninth_reg, tx_done_reg, rx_done_reg, frame_err_reg} <= 4'h0;
      end else begin
         if (wr_serial_control_reg && !fchk_reg) begin
            mode_hi_reg <= wdata_i[`ASP_SERIAL_CONTROL_REG_MODE_HI];
         end
         if (wr_serial_control_reg) begin
            mode_lo_reg <= wdata_i[`ASP_SERIAL_CONTROL_REG_MODE_LO];
            sm2_reg <= wdata_i[`ASP_SERIAL_CONTROL_REG_ADDR_EN];
            ren_reg <= wdata_i[`ASP_SERIAL_CONTROL_REG_RX_EN];
            tx_ninth_reg <= wdata_i[`ASP_SERIAL_CONTROL_REG_TX_NINTH];
         end
         rx_ninth_reg <= rx_ninth_next;
         tx_done_reg <= tx_done_next;
         rx_done_reg <= rx_done_next;
         frame_err_reg <= frame_err_next;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {double_reg, fchk_reg} <= 2'h0;
         {run_reg, tx_src_reg, rx_src_reg, fast_reg} <= 4'h0;
         reload_reg <= `ASP_RST_RELOAD;
         rx_buf_reg <= 8'h00;
         rdata_reg <= 8'h00;
         per_phase_reg <= 1'b0;
      end else begin
         per_phase_reg <= ~per_phase_reg;
         if (wr_power_control_reg) begin
            double_reg <= wdata_i[`ASP_POWER_CONTROL_REG_DOUBLE];
            fchk_reg <= wdata_i[`ASP_POWER_CONTROL_REG_FCHK];
         end
         if (wr_bdr) begin
            run_reg <= wdata_i[`ASP_BDR_RUN];
            tx_src_reg <= wdata_i[`ASP_BDR_TX_SRC];
            rx_src_reg <= wdata_i[`ASP_BDR_RX_SRC];
            fast_reg <= wdata_i[`ASP_BDR_FAST];
         end
         if (wr_reload) begin
            reload_reg <= wdata_i;
         end
         if (rx_deliver) begin
            rx_buf_reg <= rx_buf_next;
         end
         rdata_reg <= rd_i ? rd_value : 8'h00;
      end
   end

   assign rdata_o = rdata_reg;
   assign txd_o = txd_reg;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence s_tx_launch;
      tx_idle && tx_start;
   endsequence

   property p_tx_launch;
      @(posedge clock_i) disable iff (!rst_n_i)
         s_tx_launch |=> !tx_idle && !txd_o;
   endproperty
   a_tx_launch: assert property (p_tx_launch)
      else $error("data write did not start a frame");

   property p_tx_ninth;
      @(posedge clock_i) disable iff (!rst_n_i)
         s_tx_launch and !mode_8bit |=>
            tx_shift_reg[9] == $past(tx_ninth_reg);
   endproperty
   a_tx_ninth: assert property (p_tx_ninth)
      else $error("ninth bit not taken from tx_ninth_bit");

   property p_tx_stop_high;
      @(posedge clock_i) disable iff (!rst_n_i)
         !tx_idle && (tx_idx_reg == tx_last) |-> txd_o;
   endproperty
   a_tx_stop_high: assert property (p_tx_stop_high)
      else $error("stop bit not high");

   property p_ti_at_stop;
      @(posedge clock_i) disable iff (!rst_n_i)
         tx_set_ti |=> tx_done_reg && (tx_idx_reg == tx_last);
   endproperty
   a_ti_at_stop: assert property (p_ti_at_stop)
      else $error("transmit complete not set after last data bit");

   property p_rx_edge;
      @(posedge clock_i) disable iff (!rst_n_i)
         rx_active && ($past(rx_state_reg) == asp_pkg::ASP_RX_IDLE)
            |-> $past(rx_fall);
   endproperty
   a_rx_edge: assert property (p_rx_edge)
      else $error("reception began without a falling edge");

   property p_rx_reject;
      @(posedge clock_i) disable iff (!rst_n_i)
         rx_decide && (rx_idx_reg == 4'h0) && rx_maj
            |=> rx_state_reg == asp_pkg::ASP_RX_IDLE
            ##1 !rx_done_reg || $past(rx_done_reg);
   endproperty
   a_rx_reject: assert property (p_rx_reject)
      else $error("false start bit not rejected");

   property p_fe_sticky;
      @(posedge clock_i) disable iff (!rst_n_i)
         frame_err_reg && !(wr_serial_control_reg && fchk_reg) |=> frame_err_reg;
   endproperty
   a_fe_sticky: assert property (p_fe_sticky)
      else $error("framing error cleared without software");

   property p_fe_set;
      @(posedge clock_i) disable iff (!rst_n_i)
         set_ferr |=> frame_err_reg;
   endproperty
   a_fe_set: assert property (p_fe_set)
      else $error("bad stop bit not flagged");

   property p_fe_disabled;
      @(posedge clock_i) disable iff (!rst_n_i)
         !fchk_reg && !frame_err_reg |=> !frame_err_reg;
   endproperty
   a_fe_disabled: assert property (p_fe_disabled)
      else $error("framing error set while check disabled");

   property p_ri_at_stop;
      @(posedge clock_i) disable iff (!rst_n_i)
         $rose(rx_done_reg) && $past(fchk_reg) && !$past(wr_serial_control_reg)
            |-> $past(rx_idx_reg) == $past(rx_last);
   endproperty
   a_ri_at_stop: assert property (p_ri_at_stop)
      else $error("receive complete not at stop bit");

endmodule // asp_serial_port

// File: logic/asp_params.svh
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define ASP_ADDR_POWER_CTRL 8'h87
`define ASP_ADDR_BAUD_RELOAD 8'h91
`define ASP_ADDR_SERIAL_CTRL 8'h98
`define ASP_ADDR_DATA_BUF 8'h99
`define ASP_ADDR_BAUD_CTRL 8'h9B

// ****************************************************************
// Field positions
// ****************************************************************
`define ASP_POWER_CONTROL_REG_DOUBLE 7
`define ASP_POWER_CONTROL_REG_FCHK 6
`define ASP_SERIAL_CONTROL_REG_MODE_HI 7
`define ASP_SERIAL_CONTROL_REG_MODE_LO 6
`define ASP_SERIAL_CONTROL_REG_ADDR_EN 5
`define ASP_SERIAL_CONTROL_REG_RX_EN 4
`define ASP_SERIAL_CONTROL_REG_TX_NINTH 3
`define ASP_SERIAL_CONTROL_REG_RX_NINTH 2
`define ASP_SERIAL_CONTROL_REG_TX_DONE 1
`define ASP_SERIAL_CONTROL_REG_RX_DONE 0
`define ASP_BDR_RUN 4
`define ASP_BDR_TX_SRC 3
`define ASP_BDR_RX_SRC 2
`define ASP_BDR_FAST 1

// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define ASP_RST_RELOAD 8'h00
`define ASP_SAMPLE_LAST 4'hF
`define ASP_VOTE_A 4'h7
`define ASP_VOTE_B 4'h8
`define ASP_VOTE_C 4'h9
`define ASP_STOP_IDX_8BIT 4'h9
`define ASP_STOP_IDX_9BIT 4'hA
`define ASP_NINTH_IDX 4'h9
`define ASP_LAST_DATA_IDX 4'h8
`define ASP_PRESCALE_LAST 3'h5

`endif

// File: logic/asp_pkg.sv
package asp_pkg;

   typedef enum logic [1:0] {
      ASP_MODE_SHIFT,
      ASP_MODE_UART8,
      ASP_MODE_FIX9,
      ASP_MODE_VAR9
   } asp_mode_t;

   typedef enum logic {
      ASP_TX_IDLE,
      ASP_TX_SEND
   } asp_tx_state_t;

   typedef enum logic {
      ASP_RX_IDLE,
      ASP_RX_ACTIVE
   } asp_rx_state_t;

endpackage

// File: logic/asp_brg.sv
`timescale 1ns/1ns
`include "asp_params.svh"

module asp_brg #(
   parameter int WIDTH = 8
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic per_tick_i,
   input wire logic run_i,
   input wire logic fast_i,
   input wire logic [WIDTH-1:0] reload_i,
   output logic overflow_o
);

   generate
      if (WIDTH < 2) begin : g_bad_width
         $error("asp_brg width too small");
      end
   endgenerate

   logic [2:0] prescale_reg;
   logic [WIDTH-1:0] count_reg;
   logic overflow_reg;

   wire prescale_wrap = (prescale_reg == `ASP_PRESCALE_LAST);
   wire step = per_tick_i && run_i && (fast_i || prescale_wrap);
   wire count_full = (count_reg == {WIDTH{1'b1}});

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prescale_reg <= 3'h0;
         count_reg <= '0;
         overflow_reg <= 1'b0;
      end else begin
         if (per_tick_i && run_i) begin
            prescale_reg <= prescale_wrap ? 3'h0 : prescale_reg + 3'h1;
         end
         if (step) begin
            count_reg <= count_full ? reload_i : count_reg + 1'b1;
         end
         overflow_reg <= step && count_full;
      end
   end

   assign overflow_o = overflow_reg;

   property p_brg_stall;
      @(posedge clock_i) disable iff (!rst_n_i)
         !run_i |=> !overflow_o && $stable(count_reg);
   endproperty
   a_brg_stall: assert property (p_brg_stall)
      else $error("reload generator moved while stopped");

endmodule // asp_brg

// File: logic/asp_half_tick.sv
`timescale 1ns/1ns

module asp_half_tick (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic pulse_i,
   input wire logic double_i,
   output logic tick_o
);

   logic phase_reg;
   logic tick_reg;

   // The sampling tick is sixteen per bit, so a rate of 1/32 per bit
   // becomes every second source pulse, and doubling passes them all.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_reg <= 1'b0;
         tick_reg <= 1'b0;
      end else begin
         if (pulse_i) begin
            phase_reg <= ~phase_reg;
         end
         tick_reg <= pulse_i && (double_i || phase_reg);
      end
   end

   assign tick_o = tick_reg;

endmodule // asp_half_tick

// File: tb/asp_remote_uart.sv
`timescale 1ns/1ns

module asp_remote_uart (
   input wire logic clock_i,
   input wire logic txd_i,
   input wire logic [7:0] cap_cyc_i,
   input wire logic [7:0] tx_cyc_i,
   output logic rxd_o
);
   logic [10:0] frame;
   int frame_cnt;

   // ************
   // Sending side
   // ************
   // The line rests high between frames, as a pulled-up wire would.
   task automatic send(input logic [10:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         rxd_o <= bits[i];
         repeat (tx_cyc_i) @(posedge clock_i);
      end
      rxd_o <= 1'h1;
   endtask

   // **************
   // Receiving side
   // **************
   // Sampling mid-bit leaves half a bit of margin for tick skew.
   initial begin
      rxd_o = 1'h1;
      frame = '0;
      frame_cnt = 0;
      forever begin
         @(negedge txd_i);
         repeat (cap_cyc_i / 2) @(posedge clock_i);
         for (int i = 0; i < 11; i++) begin
            frame[i] = txd_i;
            repeat (cap_cyc_i) @(posedge clock_i);
         end
         frame_cnt++;
      end
   end
endmodule // asp_remote_uart

// File: tb/test_asp_serial_port.sv
`timescale 1ns/1ns

module test_asp_serial_port;
   logic clock_i = 1'h0;
   logic rst_n_i = 1'h0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic [7:0] cap_cyc = 8'h10;
   logic [7:0] tx_cyc = 8'h10;
   logic wr_s = 1'h0;
   logic rd_s = 1'h0;
   logic t1_on = 1'h0;
   logic t1_ovf = 1'h0;
   logic core = 1'h1;
   logic rxd;
   logic txd;
   int error_cnt = 0;
   int n_tests = 0;

   always #2 clock_i = ~clock_i;
   always @(posedge clock_i) t1_ovf <= t1_on & ~t1_ovf;

   asp_serial_port dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
      .rdata_o(rdata), .rxd_i(rxd), .txd_o(txd), .timer1_ovf_i(t1_ovf),
      .double_speed_core_i(core));

   asp_remote_uart rem_u (.clock_i(clock_i), .txd_i(txd),
      .cap_cyc_i(cap_cyc), .tx_cyc_i(tx_cyc), .rxd_o(rxd));

   // ************
   // Access tasks
   // ************
   task automatic results();
      $display("checks %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h, want %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr <= a;
      wdata <= d;
      wr_s <= 1'h1;
      @(posedge clock_i);
      wr_s <= 1'h0;
   endtask

   // Read data are valid only in the cycle after the strobe.
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock_i);
      addr <= a;
      rd_s <= 1'h1;
      @(posedge clock_i);
      rd_s <= 1'h0;
      #1 chk({3'h0, rdata}, {3'h0, e});
   endtask

   task automatic tx_chk(input logic [7:0] d, input logic [10:0] e,
                         input logic [7:0] s);
      int n;
      n = rem_u.frame_cnt;
      wr(8'h99, d);
      repeat (4 * cap_cyc) @(posedge clock_i);
      rd_chk(8'h98, s);
      repeat (9 * cap_cyc) @(posedge clock_i);
      chk(11'(rem_u.frame_cnt - n), 11'h001);
      chk(rem_u.frame, e);
      rd_chk(8'h98, s | 8'h02);
      wr(8'h98, s);
   endtask

   task automatic rx_chk(input logic [10:0] f, input int n,
                         input logic [7:0] s);
      @(posedge clock_i);
      rem_u.send(f, n);
      repeat (4) @(posedge clock_i);
      rd_chk(8'h98, s);
   endtask

   // *************
   // Test sequence
   // *************
   initial begin
      int n;
      repeat (3) @(posedge clock_i);
      rst_n_i <= 1'h1;
      rd_chk(8'h91, 8'h00);
      rd_chk(8'h98, 8'h00);
      rd_chk(8'h9B, 8'h00);
      wr(8'h91, 8'h5C);
      rd_chk(8'h91, 8'h5C);
      wr(8'h10, 8'hFF);
      rd_chk(8'h10, 8'h00);
      // Fixed-rate mode at three clock settings, all bit times known.
      for (int k = 0; k < 3; k++) begin
         core <= (k != 2);
         cap_cyc <= (k == 0) ? 8'h10 : 8'h20;
         wr(8'h87, (k == 1) ? 8'h00 : 8'h80);
         wr(8'h98, 8'h88);
         tx_chk(8'hA5, {2'h3, 8'hA5, 1'h0}, 8'h88);
      end
      wr(8'h98, 8'h00);
      n = rem_u.frame_cnt;
      wr(8'h99, 8'h55);
      repeat (600) @(posedge clock_i);
      chk(11'(rem_u.frame_cnt - n), 11'h000);
      wr(8'h9B, 8'h1E);
      wr(8'h91, 8'hFE);
      core <= 1'h1;
      tx_cyc <= 8'h20;
      wr(8'h98, 8'h50);
      // The generator climbs from zero once before the first reload.
      repeat (300) @(posedge clock_i);
      tx_chk(8'h3C, {2'h3, 8'h3C, 1'h0}, 8'h50);
      rx_chk({2'h3, 8'h5A, 1'h0}, 10, 8'h55);
      rd_chk(8'h99, 8'h5A);
      wr(8'h98, 8'h40);
      rx_chk({2'h3, 8'h5A, 1'h0}, 10, 8'h40);
      // Transmit on the timer, receive on the internal generator.
      t1_on <= 1'h1;
      wr(8'h9B, 8'h16);
      wr(8'h91, 8'hFF);
      tx_cyc <= 8'h10;
      wr(8'h98, 8'hD0);
      tx_chk(8'hC3, {2'h2, 8'hC3, 1'h0}, 8'hD0);
      for (int b = 0; b < 2; b++) begin
         rx_chk({1'h1, b[0], 8'h81, 1'h0}, 11,
                b[0] ? 8'hD5 : 8'hD1);
         wr(8'h98, 8'hD0);
      end
      // A low glitch shorter than half a bit must not start a frame.
      tx_cyc <= 8'h04;
      rx_chk(11'h7FE, 1, 8'hD0);
      tx_cyc <= 8'h10;
      rd_chk(8'h99, 8'h81);
      rx_chk({2'h0, 8'h33, 1'h0}, 11, 8'hD1);
      wr(8'h87, 8'hC0);
      rd_chk(8'h98, 8'h51);
      wr(8'h98, 8'h50);
      rx_chk({2'h0, 8'h33, 1'h0}, 11, 8'hD1);
      wr(8'h98, 8'hD0);
      rx_chk({2'h3, 8'h33, 1'h0}, 11, 8'hD5);
      wr(8'h98, 8'h50);
      rd_chk(8'h98, 8'h50);
      wr(8'h87, 8'h80);
      rd_chk(8'h98, 8'hD0);
      results();
   end

   // The whole sequence needs well under half of this span.
   initial begin
      repeat (40000) @(posedge clock_i);
      error_cnt++;
      results();
   end
endmodule // test_asp_serial_port
